// *** rtl/rtcc_alarm_match.sv ***
// minute and hour alarm comparator with the sticky alarm hit flag
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_consts.svh"

module rtcc_alarm_match (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // current time and alarm registers
  input wire rtcc_pkg::rtcc_time_t now_in,
  input wire logic [7:0] alarm_min_in,
  input wire logic [7:0] alarm_hr_in,
  // flag control
  input wire logic flag_clr_in,
  output logic alarm_hit_flag_out
);

  logic minute_match_disable;
  logic hour_match_disable;
  logic match_now;
  logic match_prev_reg;

  // ----------------------------------------------------------------------------
  // comparison
  // ----------------------------------------------------------------------------
  // disabled registers count as matching; nothing enabled means no alarm
  assign minute_match_disable = alarm_min_in[`RTCC_BIT_MATCH_DIS];
  assign hour_match_disable = alarm_hr_in[`RTCC_BIT_MATCH_DIS];
  assign match_now = !(minute_match_disable && hour_match_disable)
    && (minute_match_disable || (alarm_min_in[6:0] == now_in.minutes))
    && (hour_match_disable || (alarm_hr_in[5:0] == now_in.hours));

  // previous match, so only a fresh match sets the flag
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      match_prev_reg <= 1'b0;
    end else begin
      match_prev_reg <= match_now;
    end
  end

  // sticky flag; a fresh match in the clearing cycle wins
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alarm_hit_flag_out <= 1'b0;
    end else if (match_now && !match_prev_reg) begin
      alarm_hit_flag_out <= 1'b1;
    end else if (flag_clr_in) begin
      alarm_hit_flag_out <= 1'b0;
    end
  end

endmodule : rtcc_alarm_match
`default_nettype wire

// *** rtl/rtcc_calendar.sv ***
// calendar counter bank with access freeze, pending tick and minute/hour alarm
// What this block does
// - minutes kept BCD, tens bits 6..4
// - 12 hour: afternoon bit 5, tens bit 4
// - 24 hour: tens 0 to 2 in bits 5..4
// - hour format chosen by control select bit
// - day of month BCD, tens bits 5..4
// - February 29 when year divisible by 4
// - weekday 0 to 6 in bits 2..0, wraps
// - months BCD 01 to 12, tens bit 4
// - years two BCD digits, bits 7..0
// - counters frozen while host access runs
// - one missed tick replayed after access ends
// - only enabled alarm registers are compared
// - minute alarm: disable bit 7, BCD minute
// - hour alarm: disable bit 7, bit 6 unused
// - hour alarm 24 hour tens bits 5..4
// - seconds BCD, sticky oscillator stop flag bit 7
// - alarm flag set on fresh full match
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_consts.svh"

module rtcc_calendar #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // timing sources
  input wire logic tick_1hz_in,
  input wire logic osc_stopped_in,
  // control bits from the control register
  input wire logic hour_mode_12_in,
  input wire logic alarm_flag_clr_in,
  // register access from the serial front end
  input wire logic access_active_in,
  input wire rtcc_pkg::rtcc_reg_req_t req_in,
  output logic [7:0] rdata_out,
  // status
  output logic alarm_hit_flag_out,
  output logic tick_pending_out
);

  // ----------------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------------
  if (ADDR_W != 4) begin : g_bad_addr_w
    $error("rtcc_calendar: ADDR_W must be 4");
  end

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic [6:0] sec_reg;
  logic osc_stop_flag_reg;
  logic [6:0] min_reg;
  logic [5:0] hr_reg;
  logic [5:0] day_reg;
  logic [2:0] wday_reg;
  logic [4:0] mon_reg;
  logic [7:0] year_reg;
  logic [7:0] alm_min_reg;
  logic [7:0] alm_hr_reg;
  logic [6:0] sec_next;
  logic [6:0] min_next;
  logic [5:0] hr_next;
  logic [5:0] day_next;
  logic [2:0] wday_next;
  logic [4:0] mon_next;
  logic [7:0] year_next;
  rtcc_pkg::rtcc_cnt_state_t cnt_state_reg;
  logic osc_sync1_reg;
  logic osc_sync2_reg;
  logic apply_tick;
  logic leap_year;
  logic [5:0] month_last_day;
  logic wr_hit;
  rtcc_pkg::rtcc_time_t now_time;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // two digit bcd increment, caller handles the wrap value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : bcd_inc

  // ----------------------------------------------------------------------------
  // oscillator stop input synchroniser
  // ----------------------------------------------------------------------------
  // the stop indication comes from the oscillator domain
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_sync1_reg <= 1'b0;
      osc_sync2_reg <= 1'b0;
    end else begin
      osc_sync1_reg <= osc_stopped_in;
      osc_sync2_reg <= osc_sync1_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // freeze and pending tick
  // ----------------------------------------------------------------------------
  // only one tick can be held, so an access longer than a second loses time
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_state_reg <= rtcc_pkg::RTCC_RUN;
    end else begin
      case (cnt_state_reg)
        rtcc_pkg::RTCC_RUN: begin
          // a tick in the very cycle the frame opens must be held, not lost
          if (access_active_in && tick_1hz_in) begin
            cnt_state_reg <= rtcc_pkg::RTCC_FROZEN_PEND;
          end else if (access_active_in) begin
            cnt_state_reg <= rtcc_pkg::RTCC_FROZEN;
          end
        end
        rtcc_pkg::RTCC_FROZEN: begin
          if (!access_active_in) begin
            cnt_state_reg <= rtcc_pkg::RTCC_RUN;
          end else if (tick_1hz_in) begin
            cnt_state_reg <= rtcc_pkg::RTCC_FROZEN_PEND;
          end
        end
        rtcc_pkg::RTCC_FROZEN_PEND: begin
          if (!access_active_in) begin
            cnt_state_reg <= rtcc_pkg::RTCC_RUN;
          end
        end
        default: begin
          cnt_state_reg <= rtcc_pkg::RTCC_RUN;
        end
      endcase
    end
  end

  // increment when running, or replay the held tick when the access ends
  assign apply_tick = !access_active_in && (tick_1hz_in ||
    (cnt_state_reg == rtcc_pkg::RTCC_FROZEN_PEND));
  assign tick_pending_out = (cnt_state_reg == rtcc_pkg::RTCC_FROZEN_PEND);

  // ----------------------------------------------------------------------------
  // calendar arithmetic
  // ----------------------------------------------------------------------------
  // divisible by 4: even tens with units 0/4/8, odd tens with units 2/6
  assign leap_year = year_reg[4] ? (year_reg[3:0] == 4'h2 || year_reg[3:0] == 4'h6)
    : (year_reg[3:0] == 4'h0 || year_reg[3:0] == 4'h4 || year_reg[3:0] == 4'h8);

  // last day of the current month in bcd
  always_comb begin
    case (mon_reg)
      `RTCC_FEB: month_last_day = leap_year ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_last_day = 6'h30;
      default: month_last_day = 6'h31;
    endcase
  end

  // one second step with the full carry ripple
  always_comb begin
    logic day_adv;
    logic mon_adv;
    logic min_carry;
    logic hr_carry;
    logic year_adv;
    day_adv = 1'b0;
    mon_adv = 1'b0;
    min_carry = 1'b0;
    hr_carry = 1'b0;
    year_adv = 1'b0;
    sec_next = sec_reg;
    min_next = min_reg;
    hr_next = hr_reg;
    day_next = day_reg;
    wday_next = wday_reg;
    mon_next = mon_reg;
    year_next = year_reg;
    if (apply_tick) begin
      // seconds and minutes wrap at 59
      if (sec_reg == `RTCC_MAX_SEC_MIN) begin
        sec_next = 7'h00;
        min_carry = 1'b1;
      end else begin
        sec_next = 7'(bcd_inc({1'b0, sec_reg}));
      end
      if (min_carry) begin
        if (min_reg == `RTCC_MAX_SEC_MIN) begin
          min_next = 7'h00;
          hr_carry = 1'b1;
        end else begin
          min_next = 7'(bcd_inc({1'b0, min_reg}));
        end
      end
      // hours in the selected format
      if (hr_carry) begin
        if (hour_mode_12_in) begin
          if (hr_reg[4:0] == `RTCC_HR12_ELEVEN) begin
            hr_next = {~hr_reg[`RTCC_BIT_AFTERNOON], `RTCC_HR12_TWELVE};
            day_adv = hr_reg[`RTCC_BIT_AFTERNOON];
          end else if (hr_reg[4:0] == `RTCC_HR12_TWELVE) begin
            hr_next = {hr_reg[`RTCC_BIT_AFTERNOON], `RTCC_HR12_ONE};
          end else begin
            hr_next = {hr_reg[`RTCC_BIT_AFTERNOON], 5'(bcd_inc({3'h0, hr_reg[4:0]}))};
          end
        end else if (hr_reg == `RTCC_MAX_HR24) begin
          hr_next = 6'h00;
          day_adv = 1'b1;
        end else begin
          hr_next = 6'(bcd_inc({2'h0, hr_reg}));
        end
      end
      // day, weekday, month, year
      if (day_adv) begin
        wday_next = (wday_reg >= `RTCC_MAX_WEEKDAY) ? 3'h0 : wday_reg + 3'h1;
        if (day_reg >= month_last_day) begin
          day_next = 6'h01;
          mon_adv = 1'b1;
        end else begin
          day_next = 6'(bcd_inc({2'h0, day_reg}));
        end
      end
      if (mon_adv) begin
        if (mon_reg >= `RTCC_MAX_MONTH) begin
          mon_next = 5'h01;
          year_adv = 1'b1;
        end else begin
          mon_next = 5'(bcd_inc({3'h0, mon_reg}));
        end
      end
      if (year_adv) begin
        year_next = (year_reg == `RTCC_MAX_YEAR) ? 8'h00 : bcd_inc(year_reg);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // time and date registers
  // ----------------------------------------------------------------------------
  assign wr_hit = req_in.wr;

  // a host write takes precedence over the step for the same register
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sec_reg <= `RTCC_RST_SECONDS;
      min_reg <= `RTCC_RST_MINUTES;
      hr_reg <= `RTCC_RST_HOURS;
      day_reg <= `RTCC_RST_DAY;
      wday_reg <= `RTCC_RST_WEEKDAY;
      mon_reg <= `RTCC_RST_MONTH;
      year_reg <= `RTCC_RST_YEAR;
    end else begin
      sec_reg <= (wr_hit && req_in.addr == `RTCC_OFF_SECONDS) ? req_in.wdata[6:0] : sec_next;
      min_reg <= (wr_hit && req_in.addr == `RTCC_OFF_MINUTES) ? req_in.wdata[6:0] : min_next;
      hr_reg <= (wr_hit && req_in.addr == `RTCC_OFF_HOURS) ? req_in.wdata[5:0] : hr_next;
      day_reg <= (wr_hit && req_in.addr == `RTCC_OFF_DAY) ? req_in.wdata[5:0] : day_next;
      wday_reg <= (wr_hit && req_in.addr == `RTCC_OFF_WEEKDAY) ? req_in.wdata[2:0] : wday_next;
      mon_reg <= (wr_hit && req_in.addr == `RTCC_OFF_MONTH) ? req_in.wdata[4:0] : mon_next;
      year_reg <= (wr_hit && req_in.addr == `RTCC_OFF_YEAR) ? req_in.wdata : year_next;
    end
  end

  // sticky oscillator stop flag; a stop in the clearing cycle wins
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_stop_flag_reg <= `RTCC_RST_OSC_STOP;
    end else if (osc_sync2_reg) begin
      osc_stop_flag_reg <= 1'b1;
    end else if (wr_hit && req_in.addr == `RTCC_OFF_SECONDS) begin
      osc_stop_flag_reg <= req_in.wdata[`RTCC_BIT_OSC_STOP];
    end
  end

  // ----------------------------------------------------------------------------
  // alarm registers
  // ----------------------------------------------------------------------------
  // both start disabled; bit 6 of the hour alarm is not stored
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alm_min_reg <= {`RTCC_RST_MATCH_DIS, 7'h00};
      alm_hr_reg <= {`RTCC_RST_MATCH_DIS, 7'h00};
    end else if (wr_hit && req_in.addr == `RTCC_OFF_ALM_MIN) begin
      alm_min_reg <= req_in.wdata;
    end else if (wr_hit && req_in.addr == `RTCC_OFF_ALM_HR) begin
      alm_hr_reg <= {req_in.wdata[7], 1'b0, req_in.wdata[5:0]};
    end
  end

  assign now_time = '{minutes: min_reg, hours: hr_reg};

  // comparator and sticky alarm flag
  rtcc_alarm_match u_alarm (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .now_in(now_time),
    .alarm_min_in(alm_min_reg),
    .alarm_hr_in(alm_hr_reg),
    .flag_clr_in(alarm_flag_clr_in),
    .alarm_hit_flag_out(alarm_hit_flag_out)
  );

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  // registered read; unused bits and unmapped offsets read as zero
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (req_in.rd) begin
      if (req_in.addr == `RTCC_OFF_SECONDS) begin
        rdata_out <= {osc_stop_flag_reg, sec_reg};
      end else if (req_in.addr == `RTCC_OFF_MINUTES) begin
        rdata_out <= {1'b0, min_reg};
      end else if (req_in.addr == `RTCC_OFF_HOURS) begin
        rdata_out <= {2'h0, hr_reg};
      end else if (req_in.addr == `RTCC_OFF_DAY) begin
        rdata_out <= {2'h0, day_reg};
      end else if (req_in.addr == `RTCC_OFF_WEEKDAY) begin
        rdata_out <= {5'h00, wday_reg};
      end else if (req_in.addr == `RTCC_OFF_MONTH) begin
        rdata_out <= {3'h0, mon_reg};
      end else if (req_in.addr == `RTCC_OFF_YEAR) begin
        rdata_out <= year_reg;
      end else if (req_in.addr == `RTCC_OFF_ALM_MIN) begin
        rdata_out <= alm_min_reg;
      end else if (req_in.addr == `RTCC_OFF_ALM_HR) begin
        rdata_out <= alm_hr_reg;
      end else begin
        rdata_out <= `RTCC_UNMAPPED_READ;
      end
    end
  end

endmodule : rtcc_calendar
`default_nettype wire

// *** rtl/rtcc_consts.svh ***
// register offsets, field layouts and reset values of the calendar counter bank
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define RTCC_OFF_SECONDS 4'h2
`define RTCC_OFF_MINUTES 4'h3
`define RTCC_OFF_HOURS 4'h4
`define RTCC_OFF_DAY 4'h5
`define RTCC_OFF_WEEKDAY 4'h6
`define RTCC_OFF_MONTH 4'h7
`define RTCC_OFF_YEAR 4'h8
`define RTCC_OFF_ALM_MIN 4'h9
`define RTCC_OFF_ALM_HR 4'hA

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RTCC_BIT_OSC_STOP 7
`define RTCC_BIT_MATCH_DIS 7
`define RTCC_BIT_AFTERNOON 5

// ----------------------------------------------------------------------------
// reset values and counting limits
// ----------------------------------------------------------------------------
`define RTCC_RST_SECONDS 7'h00
`define RTCC_RST_MINUTES 7'h00
`define RTCC_RST_HOURS 6'h00
`define RTCC_RST_DAY 6'h01
`define RTCC_RST_WEEKDAY 3'h0
`define RTCC_RST_MONTH 5'h01
`define RTCC_RST_YEAR 8'h00
`define RTCC_RST_OSC_STOP 1'b1
`define RTCC_RST_MATCH_DIS 1'b1
`define RTCC_MAX_SEC_MIN 7'h59
`define RTCC_MAX_HR24 6'h23
`define RTCC_HR12_ELEVEN 5'h11
`define RTCC_HR12_TWELVE 5'h12
`define RTCC_HR12_ONE 5'h01
`define RTCC_MAX_WEEKDAY 3'h6
`define RTCC_MAX_MONTH 5'h12
`define RTCC_MAX_YEAR 8'h99
`define RTCC_FEB 5'h02
`define RTCC_UNMAPPED_READ 8'h00

`endif

// *** rtl/rtcc_pkg.sv ***
// types shared by the calendar counter bank
package rtcc_pkg;

  // ----------------------------------------------------------------------------
  // register access request from the serial front end
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtcc_reg_req_t;

  // current minute and hour as seen by the alarm comparator
  typedef struct packed {
    logic [6:0] minutes;
    logic [5:0] hours;
  } rtcc_time_t;

  // increment engine state
  typedef enum logic [1:0] {
    RTCC_RUN = 2'b00,
    RTCC_FROZEN = 2'b01,
    RTCC_FROZEN_PEND = 2'b10
  } rtcc_cnt_state_t;

endpackage : rtcc_pkg

// *** testbench/rtcc_calendar_properties.sv ***
// concurrent checks on the calendar counter bank ports
`timescale 1ns/1ps
`default_nettype none

module rtcc_calendar_properties (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // stimulus side
  input wire logic tick_1hz_in,
  input wire logic osc_stopped_in,
  input wire logic hour_mode_12_in,
  input wire logic alarm_flag_clr_in,
  input wire logic access_active_in,
  input wire rtcc_pkg::rtcc_reg_req_t req_in,
  // answers
  input wire logic [7:0] rdata_out,
  input wire logic alarm_hit_flag_out,
  input wire logic tick_pending_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  // --------------------------------------------------------------------------
  // sequences
  // --------------------------------------------------------------------------
  // a tick that lands while the host holds the bank
  sequence s_frozen_tick;
    access_active_in && tick_1hz_in;
  endsequence
  // a read strobe at one offset
  sequence s_rd(a);
    req_in.rd && req_in.addr == a;
  endsequence

  // --------------------------------------------------------------------------
  // freeze and replay
  // --------------------------------------------------------------------------
  chk_pend_set: assert property (s_frozen_tick |=> tick_pending_out)
    else $error("tick not held during access");
  chk_pend_cause: assert property ($rose(tick_pending_out) |-> $past(tick_1hz_in) && $past(access_active_in))
    else $error("pending raised without frozen tick");
  chk_pend_replay: assert property (tick_pending_out && !access_active_in |=> !tick_pending_out)
    else $error("held tick not replayed");

  // --------------------------------------------------------------------------
  // field layouts seen on reads (stimulus writes legal values only)
  // --------------------------------------------------------------------------
  chk_min_bcd: assert property (s_rd(4'h3) |=> rdata_out[7:4] <= 4'h5 && rdata_out[3:0] <= 4'h9)
    else $error("minutes not bcd");
  chk_hr24_bcd: assert property (s_rd(4'h4) ##0 !hour_mode_12_in |=> rdata_out[7:4] <= 4'h2)
    else $error("24 hour tens out of range");
  chk_day_bcd: assert property (s_rd(4'h5) |=> rdata_out[7:4] <= 4'h3 && rdata_out != 8'h00)
    else $error("day out of range");
  chk_wday_range: assert property (s_rd(4'h6) |=> rdata_out <= 8'h06)
    else $error("weekday out of range");
  chk_month_range: assert property (s_rd(4'h7) |=> rdata_out <= 8'h12 && rdata_out != 8'h00)
    else $error("month out of range");
  chk_hr_alarm_gap: assert property (s_rd(4'hA) |=> rdata_out[6] == 1'b0)
    else $error("hour alarm bit 6 set");

  // --------------------------------------------------------------------------
  // alarm flag
  // --------------------------------------------------------------------------
  chk_flag_sticky: assert property (alarm_hit_flag_out && !alarm_flag_clr_in |=> alarm_hit_flag_out)
    else $error("alarm flag dropped without clear");
endmodule : rtcc_calendar_properties

bind rtcc_calendar rtcc_calendar_properties u_props (.clk_sys_in, .nrst_in, .tick_1hz_in, .osc_stopped_in,
  .hour_mode_12_in, .alarm_flag_clr_in, .access_active_in, .req_in, .rdata_out, .alarm_hit_flag_out,
  .tick_pending_out);

`default_nettype wire

// *** testbench/rtcc_host_model.sv ***
// host side model: framed accesses and single byte register transfers
`timescale 1ns/1ps
`default_nettype none

module rtcc_host_model (
  // clock
  input wire logic clk_sys_in,
  // requests toward the counter bank
  output var rtcc_pkg::rtcc_reg_req_t req_out,
  output logic access_active_out,
  // read answer
  input wire logic [7:0] rdata_in
);
  // idle from time zero
  initial begin
    req_out = '0;
    access_active_out = 1'b0;
  end

  // frame edges land on the falling edge
  task open_access;
    @(negedge clk_sys_in);
    access_active_out = 1'b1;
  endtask : open_access

  // frames last a few cycles, far below one second
  task close_access;
    @(negedge clk_sys_in);
    access_active_out = 1'b0;
  endtask : close_access

  // strobe for one rising edge, then lines go to inverted junk
  task xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys_in);
    req_out = {w, ~w, a, d};
    @(negedge clk_sys_in);
    q = rdata_in;
    req_out = {2'b00, ~a, ~d};
  endtask : xfer
endmodule : rtcc_host_model

`default_nettype wire

// *** testbench/test_rtcc_calendar.sv ***
// self-checking bench for the calendar counter bank
`timescale 1ns/1ps
`default_nettype none

module test_rtcc_calendar;
  logic clk_sys_in, nrst_in, tick_1hz_in, osc_stopped_in, hour_mode_12_in, alarm_flag_clr_in;
  logic access_active_in, alarm_hit_flag_out, tick_pending_out;
  logic [7:0] rdata_out;
  logic [7:0] q;
  rtcc_pkg::rtcc_reg_req_t req_in;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [55:0] st [8];
  logic [55:0] ex [8];

  rtcc_calendar dut (.clk_sys_in, .nrst_in, .tick_1hz_in, .osc_stopped_in, .hour_mode_12_in,
    .alarm_flag_clr_in, .access_active_in, .req_in, .rdata_out, .alarm_hit_flag_out, .tick_pending_out);
  rtcc_host_model host (.clk_sys_in, .req_out(req_in), .access_active_out(access_active_in),
    .rdata_in(rdata_out));

  // --------------------------------------------------------------------------
  // clock and hang guard
  // --------------------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // the whole run needs well under 2000 cycles
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      complete_run();
    end
  end

  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task rc(input logic [3:0] a, input logic [7:0] exp);
    host.xfer(1'b0, a, 8'h00, q);
    check($sformatf("reg %h", a), q, exp);
  endtask : rc
  task wr(input logic [3:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  // seconds through years in one frame so no rollover splits them
  task set_all(input logic [55:0] t);
    host.open_access();
    for (int i = 0; i < 7; i++) wr(4'(i + 2), t[55 - 8 * i -: 8]);
    host.close_access();
  endtask : set_all
  task chk_all(input logic [55:0] t);
    host.open_access();
    for (int i = 0; i < 7; i++) rc(4'(i + 2), t[55 - 8 * i -: 8]);
    host.close_access();
  endtask : chk_all
  task tick;
    @(negedge clk_sys_in);
    tick_1hz_in = 1'b1;
    @(negedge clk_sys_in);
    tick_1hz_in = 1'b0;
  endtask : tick
  task complete_run;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    {nrst_in, tick_1hz_in, osc_stopped_in, hour_mode_12_in, alarm_flag_clr_in} = '0;
    // start values and one tick later; last three run in 12 hour mode
    st = '{56'h59_59_23_28_06_02_03, 56'h59_59_23_28_02_02_04, 56'h59_59_23_28_01_02_00,
      56'h59_59_23_31_05_12_99, 56'h59_59_23_30_01_04_19, 56'h59_59_11_15_03_06_21,
      56'h59_59_32_15_03_06_21, 56'h59_59_31_15_03_06_21};
    ex = '{56'h00_00_00_01_00_03_03, 56'h00_00_00_29_03_02_04, 56'h00_00_00_29_02_02_00,
      56'h00_00_00_01_06_01_00, 56'h00_00_00_01_02_05_19, 56'h00_00_32_15_03_06_21,
      56'h00_00_21_15_03_06_21, 56'h00_00_12_16_04_06_21};
    repeat (16) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    chk_all(56'h80_00_00_01_00_01_00);
    rc(4'h9, 8'h80);
    rc(4'hA, 8'h80);
    rc(4'hF, 8'h00);
    // oscillator stop flag is sticky until written back
    wr(4'h2, 8'h00);
    rc(4'h2, 8'h00);
    osc_stopped_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    osc_stopped_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    rc(4'h2, 8'h80);
    wr(4'h2, 8'h00);
    rc(4'h2, 8'h00);
    // minute alarm armed away from a match, a fresh match sets the flag, then one that the hour alarm vetoes
    set_all(56'h59_59_10_01_00_01_00);
    wr(4'h9, 8'h00);
    repeat (2) @(negedge clk_sys_in);
    check("flag", {7'h00, alarm_hit_flag_out}, 8'h00);
    tick();
    repeat (2) @(negedge clk_sys_in);
    check("flag", {7'h00, alarm_hit_flag_out}, 8'h01);
    alarm_flag_clr_in = 1'b1;
    @(negedge clk_sys_in);
    alarm_flag_clr_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    check("flag", {7'h00, alarm_hit_flag_out}, 8'h00);
    wr(4'hA, 8'h45);
    rc(4'hA, 8'h05);
    set_all(56'h59_59_10_01_00_01_00);
    tick();
    repeat (3) @(negedge clk_sys_in);
    check("flag", {7'h00, alarm_hit_flag_out}, 8'h00);
    // two ticks inside one frame give exactly one step afterwards
    set_all(56'h58_00_00_01_00_01_00);
    // the first tick lands in the very cycle the frame opens
    fork
      host.open_access();
      tick();
    join
    tick();
    check("pending", {7'h00, tick_pending_out}, 8'h01);
    rc(4'h2, 8'h58);
    host.close_access();
    repeat (2) @(negedge clk_sys_in);
    check("pending", {7'h00, tick_pending_out}, 8'h00);
    rc(4'h2, 8'h59);
    // rollovers: month ends, leap years, year wrap, 12 hour turns
    for (int i = 0; i < 8; i++) begin
      hour_mode_12_in = (i > 4);
      set_all(st[i]);
      tick();
      chk_all(ex[i]);
    end
    complete_run();
  end
endmodule : test_rtcc_calendar

`default_nettype wire
